// File: hdl/swrmc_pkg.sv
// package: constants, types and register map of the sleep/wake resource mode control
//
// Overview of operation
// - sleep request in ACTIVE starts active_to_sleep_seq if CTRL bit 0 unmasks sleep and no interrupt is pending
// - in SLEEP only an interrupt or the sleep pin can wake the device
// - wake acts only in SLEEP, launching sleep_to_active_seq; an off request in SLEEP launches sleep_to_off_seq
// - each resource in sleep mode, in any state, uses its own sleep-state mode control bit
// - sleep-pin resources change mode only inside the sleep/wake sequences or on entering OFF
// - direct-pin resources switch mode at once when their pin changes
// - a resource stays active while any assigned pin is active
// - direct pin toggles switch immediately, sleep pin toggles are sequenced
// - all three pin polarities are configurable; direct pins default active high
// - sleep pin defaults to active low
// - assignment bits per resource, grouped as misc, switcher and linear classes
// - all resources on one direct pin switch together in the same cycle
// - sleep-pin-only resources switch in the stored sequence order
// - a resource with no pin assignment stays active forever
// - sequences set switchers, linears, 32 kHz clock and regulator enable output
// - the sequencer waits the stored step_delay before each step
// - resources in no sequence stay off; software may enable them afterwards
// - off requests win over everything and have no gating
// - sequences are fixed register accesses in read-only storage
package swrmc_pkg;

  // =============================================================
  // resources
  localparam int N_SW    = 5;
  localparam int N_LIN   = 5;
  localparam int N_MISC  = 2;
  localparam int N_RES   = 12;
  localparam int SW_LO   = 0;
  localparam int LIN_LO  = 5;
  localparam int MISC_LO = 10;
  localparam logic [3:0] RES_SW2    = 4'h2;
  localparam logic [3:0] RES_LIN0   = 4'h5;
  localparam logic [3:0] RES_CLK32K = 4'ha;
  localparam logic [3:0] RES_REG_EN = 4'hb;
  localparam logic [3:0] RES_ALL    = 4'hf;

  // =============================================================
  // register map (byte offsets)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_POLARITY = 8'h04;
  localparam logic [7:0] OFS_ASG_MISC = 8'h08;
  localparam logic [7:0] OFS_ASG_SW   = 8'h0c;
  localparam logic [7:0] OFS_ASG_LIN  = 8'h10;
  localparam logic [7:0] OFS_MODE     = 8'h14;
  localparam logic [7:0] OFS_SW_EN    = 8'h18;
  localparam logic [7:0] OFS_STATUS   = 8'h1c;
  localparam logic [7:0] OFS_EDGES    = 8'h20;
  localparam logic [7:0] OFS_RES_STAT = 8'h24;
  localparam int F_ASG_S    = 0;
  localparam int F_ASG_A    = 8;
  localparam int F_ASG_B    = 16;
  localparam int F_MODE_SLP = 16;
  localparam int F_STAT_RUN = 3;
  localparam int F_RES_LP   = 16;
  localparam logic [11:0] MODE_ACT_RST = 12'hfff;
  localparam logic [11:0] MODE_SLP_RST = 12'h000;
  localparam logic [2:0]  POL_RST      = 3'h0;
  localparam logic [2:0]  PIN_IDLE     = 3'h1;

  // =============================================================
  // timing
  localparam int CLK_NS           = 40;
  localparam int STEP_TICK_NS     = 10000;
  localparam int STEP_TICK_CYC_DF = (STEP_TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICK_W           = 16;

  // =============================================================
  // sequence step word: last, op, resource, delay in ticks
  localparam int STP_W      = 16;
  localparam int STP_LAST   = 15;
  localparam int STP_OP_LO  = 12;
  localparam int STP_RES_LO = 8;
  localparam int DLY_W      = 8;
  localparam int SEQ_AW     = 4;

  typedef enum logic [1:0] {
    OP_EN  = 2'b00,
    OP_DIS = 2'b01,
    OP_SLP = 2'b10,
    OP_ACT = 2'b11
  } swrmc_op_t;

  typedef enum logic [2:0] {
    ST_OFF  = 3'b000,
    ST_ACT  = 3'b001,
    ST_SLP  = 3'b010,
    ST_LOAD = 3'b011,
    ST_WAIT = 3'b100
  } swrmc_state_t;

  localparam logic [SEQ_AW-1:0] SEQ_UP      = 4'h0;
  localparam logic [SEQ_AW-1:0] SEQ_DOWN    = 4'h4;
  localparam logic [SEQ_AW-1:0] SEQ_SLEEP   = 4'h8;
  localparam logic [SEQ_AW-1:0] SEQ_WAKE    = 4'hb;
  localparam logic [SEQ_AW-1:0] SEQ_SLP_OFF = 4'hd;

  function automatic logic [STP_W-1:0] mk_step(input logic last, input swrmc_op_t op,
                                               input logic [3:0] res,
                                               input logic [DLY_W-1:0] dly);
    mk_step = {last, 1'b0, op, res, dly};
  endfunction

endpackage

// File: hdl/swrmc_pin_sync.sv
// two-flop pin synchroniser with edge detection
`timescale 1ns/1ns
`default_nettype none
module swrmc_pin_sync #(
  parameter int           W    = 3,
  parameter logic [W-1:0] IDLE = '0
) (
  input  wire logic         clk,    // system clock
  input  wire logic         srst,   // sync reset
  input  wire logic         ce,     // clock enable
  input  wire logic [W-1:0] pin,    // raw pins
  output logic      [W-1:0] lvl,    // synchronised level
  output logic      [W-1:0] rise,   // one-cycle rising pulse
  output logic      [W-1:0] fall    // one-cycle falling pulse
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // only s2 and s3 feed logic; s1 may be metastable
      always_ff @(posedge clk) begin
        // reset to the idle level so no false edge follows reset
        if (srst) begin
          s1_r[g] <= IDLE[g];
          s2_r[g] <= IDLE[g];
          s3_r[g] <= IDLE[g];
        end else if (ce) begin
          s1_r[g] <= pin[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
        end
      end
      assign lvl[g]  = s2_r[g];
      assign rise[g] = ce & s2_r[g] & ~s3_r[g];
      assign fall[g] = ce & ~s2_r[g] & s3_r[g];
    end
  endgenerate

endmodule
`default_nettype wire

// File: hdl/swrmc_seq_rom.sv
// fixed power sequence store, registered read
`timescale 1ns/1ns
`default_nettype none
module swrmc_seq_rom
  import swrmc_pkg::*;
(
  input  wire logic              clk,   // system clock
  input  wire logic              srst,  // sync reset
  input  wire logic              ce,    // clock enable
  input  wire logic [SEQ_AW-1:0] addr,  // step address
  output logic      [STP_W-1:0]  q      // step word, one cycle later
);

  logic [STP_W-1:0] word;

  // contents are constants: no write path exists
  always_comb begin
    unique case (addr)
      4'h0:    word = mk_step(1'b0, OP_EN,  RES_SW2,    8'h01);
      4'h1:    word = mk_step(1'b0, OP_EN,  RES_LIN0,   8'h02);
      4'h2:    word = mk_step(1'b0, OP_EN,  RES_CLK32K, 8'h01);
      4'h3:    word = mk_step(1'b1, OP_EN,  RES_REG_EN, 8'h01);
      4'h4:    word = mk_step(1'b0, OP_DIS, RES_REG_EN, 8'h01);
      4'h5:    word = mk_step(1'b0, OP_DIS, RES_CLK32K, 8'h01);
      4'h6:    word = mk_step(1'b0, OP_DIS, RES_LIN0,   8'h01);
      4'h7:    word = mk_step(1'b1, OP_DIS, RES_ALL,    8'h01);
      4'h8:    word = mk_step(1'b0, OP_SLP, RES_LIN0,   8'h01);
      4'h9:    word = mk_step(1'b0, OP_SLP, RES_SW2,    8'h01);
      4'ha:    word = mk_step(1'b1, OP_SLP, RES_ALL,    8'h01);
      4'hb:    word = mk_step(1'b0, OP_ACT, RES_SW2,    8'h01);
      4'hc:    word = mk_step(1'b1, OP_ACT, RES_ALL,    8'h01);
      4'hd:    word = mk_step(1'b0, OP_DIS, RES_REG_EN, 8'h01);
      4'he:    word = mk_step(1'b0, OP_DIS, RES_CLK32K, 8'h01);
      default: word = mk_step(1'b1, OP_DIS, RES_ALL,    8'h01);
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else if (ce) begin
      q <= word;
    end
  end

endmodule
`default_nettype wire

// File: hdl/swrmc_top.sv
// sleep/wake state control, resource mode control and AHB-Lite registers
`timescale 1ns/1ns
`default_nettype none
module swrmc_top
  import swrmc_pkg::*;
#(
  parameter int STEP_TICK_CYC = STEP_TICK_CYC_DF
) (
  input  wire logic             clk,                // 25 MHz clock
  input  wire logic             srst,               // sync reset, high
  input  wire logic             ce,                 // clock enable
  input  wire logic             hsel,               // ahb select
  input  wire logic [31:0]      haddr,              // ahb address
  input  wire logic [1:0]       htrans,             // ahb transfer type
  input  wire logic             hwrite,             // ahb write
  input  wire logic [2:0]       hsize,              // ahb size
  input  wire logic [31:0]      hwdata,             // ahb write data
  input  wire logic             hready,             // ahb bus ready
  output logic      [31:0]      hrdata,             // ahb read data
  output logic                  hreadyout,          // ahb slave ready
  output logic                  hresp,              // ahb response
  input  wire logic             sleep_request_pin,  // sleep/wake pin
  input  wire logic             direct_mode_ctrl_a, // direct mode pin a
  input  wire logic             direct_mode_ctrl_b, // direct mode pin b
  input  wire logic             irq_pending,        // unmasked interrupt pending
  input  wire logic             on_req,             // gated on request
  input  wire logic             off_req,            // off request
  output logic      [N_RES-1:0] res_on,             // resource enabled
  output logic      [N_RES-1:0] res_lowpower,       // resource in sleep mode
  output logic      [2:0]       pwr_state           // power state code
);

  // =============================================================
  // registers
  logic              sleep_unmask_r;
  logic [2:0]        pol_r;
  logic [N_RES-1:0]  asg_s_r;
  logic [N_RES-1:0]  asg_a_r;
  logic [N_RES-1:0]  asg_b_r;
  logic [N_RES-1:0]  mode_act_r;
  logic [N_RES-1:0]  mode_slp_r;
  logic [N_RES-1:0]  sw_en_r;
  logic [5:0]        edg_r;
  logic [N_RES-1:0]  seq_en_r;
  logic [N_RES-1:0]  seq_act_r;
  logic [N_RES-1:0]  res_on_r;
  logic [N_RES-1:0]  res_lp_r;
  swrmc_state_t      state_r;
  swrmc_state_t      tgt_r;
  logic [SEQ_AW-1:0] addr_r;
  logic [DLY_W-1:0]  dly_r;
  logic [TICK_W-1:0] tick_r;
  logic              ap_wr_r;
  logic [7:0]        ap_ofs_r;
  logic              rd_pend_r;
  logic [31:0]       hrdata_r;

  // =============================================================
  // pins
  logic [2:0]       pin_lvl;
  logic [2:0]       pin_rise;
  logic [2:0]       pin_fall;
  logic             sleep_asrt;
  logic             a_act;
  logic             b_act;

  swrmc_pin_sync #(
    .W    (3),
    .IDLE (PIN_IDLE)
  ) u_sync (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .pin  ({direct_mode_ctrl_b, direct_mode_ctrl_a, sleep_request_pin}),
    .lvl  (pin_lvl),
    .rise (pin_rise),
    .fall (pin_fall)
  );

  // polarity bit 0 means default sense
  assign sleep_asrt = (pin_lvl[0] == pol_r[0]);
  assign a_act      = pin_lvl[1] ^ pol_r[1];
  assign b_act      = pin_lvl[2] ^ pol_r[2];

  // =============================================================
  // sequence store
  logic [STP_W-1:0] step_q;
  swrmc_op_t        q_op;
  logic [3:0]       q_res;
  logic [DLY_W-1:0] q_dly;
  logic             q_last;

  swrmc_seq_rom u_rom (
    .clk  (clk),
    .srst (srst),
    .ce   (ce),
    .addr (addr_r),
    .q    (step_q)
  );

  assign q_last = step_q[STP_LAST];
  assign q_op   = swrmc_op_t'(step_q[STP_OP_LO +: 2]);
  assign q_res  = step_q[STP_RES_LO +: 4];
  assign q_dly  = step_q[DLY_W-1:0];

  // =============================================================
  // power state machine
  logic running;
  logic abort;
  logic tick_done;
  logic step_fire;

  assign running   = (state_r == ST_LOAD) | (state_r == ST_WAIT);
  assign abort     = running & off_req & (tgt_r != ST_OFF);
  assign tick_done = (tick_r == TICK_W'(STEP_TICK_CYC - 1));
  assign step_fire = (state_r == ST_WAIT) & ~abort & (dly_r == q_dly);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_OFF;
      tgt_r   <= ST_OFF;
      addr_r  <= SEQ_UP;
    end else if (ce) begin
      unique case (state_r)
        ST_OFF: begin
          if (on_req & ~off_req) begin
            addr_r  <= SEQ_UP;
            tgt_r   <= ST_ACT;
            state_r <= ST_LOAD;
          end
        end
        ST_ACT: begin
          if (off_req) begin
            addr_r  <= SEQ_DOWN;
            tgt_r   <= ST_OFF;
            state_r <= ST_LOAD;
          end else if (sleep_unmask_r & sleep_asrt & ~irq_pending) begin
            addr_r  <= SEQ_SLEEP;
            tgt_r   <= ST_SLP;
            state_r <= ST_LOAD;
          end
        end
        ST_SLP: begin
          if (off_req) begin
            addr_r  <= SEQ_SLP_OFF;
            tgt_r   <= ST_OFF;
            state_r <= ST_LOAD;
          end else if (~sleep_asrt | irq_pending) begin
            addr_r  <= SEQ_WAKE;
            tgt_r   <= ST_ACT;
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (abort) begin
            addr_r <= SEQ_DOWN;
            tgt_r  <= ST_OFF;
          end else begin
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (abort) begin
            addr_r  <= SEQ_DOWN;
            tgt_r   <= ST_OFF;
            state_r <= ST_LOAD;
          end else if (step_fire) begin
            if (q_last) begin
              state_r <= tgt_r;
            end else begin
              addr_r  <= addr_r + 1'b1;
              state_r <= ST_LOAD;
            end
          end
        end
        default: state_r <= ST_OFF;
      endcase
    end
  end

  // step delay counter, ticks of STEP_TICK_CYC cycles
  always_ff @(posedge clk) begin
    if (srst) begin
      dly_r  <= '0;
      tick_r <= '0;
    end else if (ce) begin
      if (state_r != ST_WAIT) begin
        dly_r  <= '0;
        tick_r <= '0;
      end else if (tick_done) begin
        dly_r  <= dly_r + 1'b1;
        tick_r <= '0;
      end else begin
        tick_r <= tick_r + 1'b1;
      end
    end
  end

  // =============================================================
  // step execution
  logic [N_RES-1:0] sel;
  assign sel = (q_res == RES_ALL) ? '1 : ({{(N_RES-1){1'b0}}, 1'b1} << q_res);

  always_ff @(posedge clk) begin
    if (srst) begin
      seq_en_r  <= '0;
      seq_act_r <= '1;
    end else if (ce & step_fire) begin
      unique case (q_op)
        OP_EN:  seq_en_r  <= seq_en_r | sel;
        OP_DIS: seq_en_r  <= seq_en_r & ~sel;
        OP_SLP: seq_act_r <= seq_act_r & ~(sel & asg_s_r);
        OP_ACT: seq_act_r <= seq_act_r | (sel & asg_s_r);
      endcase
    end else if (ce & (state_r == ST_OFF)) begin
      // a cut sleep sequence must not leave resources parked after power-up
      seq_act_r <= '1;
    end
  end

  // =============================================================
  // per-resource mode
  genvar g;
  generate
    for (g = 0; g < N_RES; g++) begin : g_res
      logic active;
      logic en;
      // any active pin keeps the mode; unassigned stays active
      assign active = (asg_s_r[g] & seq_act_r[g]) | (asg_a_r[g] & a_act)
                    | (asg_b_r[g] & b_act)
                    | ~(asg_s_r[g] | asg_a_r[g] | asg_b_r[g]);
      assign en     = seq_en_r[g] | sw_en_r[g];
      always_ff @(posedge clk) begin
        if (srst) begin
          res_on_r[g] <= 1'b0;
          res_lp_r[g] <= 1'b0;
        end else if (ce) begin
          res_on_r[g] <= en & (active ? mode_act_r[g] : mode_slp_r[g]);
          res_lp_r[g] <= ~active;
        end
      end
    end
  endgenerate

  assign res_on       = res_on_r;
  assign res_lowpower = res_lp_r;
  assign pwr_state    = state_r;

  // =============================================================
  // ahb-lite slave: writes zero wait, reads one wait
  logic accept;
  logic wr_en;
  assign accept    = hsel & htrans[1] & hready;
  assign wr_en     = ce & ap_wr_r & ~rd_pend_r;
  assign hreadyout = ~rd_pend_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      ap_wr_r   <= 1'b0;
      ap_ofs_r  <= '0;
      rd_pend_r <= 1'b0;
    end else if (ce) begin
      ap_wr_r   <= accept & hwrite;
      rd_pend_r <= accept & ~hwrite;
      if (accept) begin
        ap_ofs_r <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_unmask_r <= 1'b0;
      pol_r          <= POL_RST;
      asg_s_r        <= '0;
      asg_a_r        <= '0;
      asg_b_r        <= '0;
      mode_act_r     <= MODE_ACT_RST;
      mode_slp_r     <= MODE_SLP_RST;
    end else if (wr_en) begin
      unique case (ap_ofs_r)
        OFS_CTRL:     sleep_unmask_r <= hwdata[0];
        OFS_POLARITY: pol_r <= hwdata[2:0];
        OFS_ASG_MISC: begin
          asg_s_r[MISC_LO +: N_MISC] <= hwdata[F_ASG_S +: N_MISC];
          asg_a_r[MISC_LO +: N_MISC] <= hwdata[F_ASG_A +: N_MISC];
          asg_b_r[MISC_LO +: N_MISC] <= hwdata[F_ASG_B +: N_MISC];
        end
        OFS_ASG_SW: begin
          asg_s_r[SW_LO +: N_SW] <= hwdata[F_ASG_S +: N_SW];
          asg_a_r[SW_LO +: N_SW] <= hwdata[F_ASG_A +: N_SW];
          asg_b_r[SW_LO +: N_SW] <= hwdata[F_ASG_B +: N_SW];
        end
        OFS_ASG_LIN: begin
          asg_s_r[LIN_LO +: N_LIN] <= hwdata[F_ASG_S +: N_LIN];
          asg_a_r[LIN_LO +: N_LIN] <= hwdata[F_ASG_A +: N_LIN];
          asg_b_r[LIN_LO +: N_LIN] <= hwdata[F_ASG_B +: N_LIN];
        end
        OFS_MODE: begin
          mode_act_r <= hwdata[N_RES-1:0];
          mode_slp_r <= hwdata[F_MODE_SLP +: N_RES];
        end
        default: ;
      endcase
    end
  end

  // software enable only once a sequence has completed; off clears it
  always_ff @(posedge clk) begin
    if (srst) begin
      sw_en_r <= '0;
    end else if (ce) begin
      if (state_r == ST_OFF) begin
        sw_en_r <= '0;
      end else if (wr_en & (ap_ofs_r == OFS_SW_EN) & ~running) begin
        sw_en_r <= hwdata[N_RES-1:0];
      end
    end
  end

  // sticky pin edges, write one to clear, a new edge beats the clear
  logic [5:0] edg_clr;
  assign edg_clr = (wr_en & (ap_ofs_r == OFS_EDGES)) ? hwdata[5:0] : '0;

  always_ff @(posedge clk) begin
    if (srst) begin
      edg_r <= '0;
    end else if (ce) begin
      edg_r <= (edg_r & ~edg_clr) | {pin_fall, pin_rise};
    end
  end

  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    unique case (ap_ofs_r)
      OFS_CTRL:     rd_val[0] = sleep_unmask_r;
      OFS_POLARITY: rd_val[2:0] = pol_r;
      OFS_ASG_MISC: begin
        rd_val[F_ASG_S +: N_MISC] = asg_s_r[MISC_LO +: N_MISC];
        rd_val[F_ASG_A +: N_MISC] = asg_a_r[MISC_LO +: N_MISC];
        rd_val[F_ASG_B +: N_MISC] = asg_b_r[MISC_LO +: N_MISC];
      end
      OFS_ASG_SW: begin
        rd_val[F_ASG_S +: N_SW] = asg_s_r[SW_LO +: N_SW];
        rd_val[F_ASG_A +: N_SW] = asg_a_r[SW_LO +: N_SW];
        rd_val[F_ASG_B +: N_SW] = asg_b_r[SW_LO +: N_SW];
      end
      OFS_ASG_LIN: begin
        rd_val[F_ASG_S +: N_LIN] = asg_s_r[LIN_LO +: N_LIN];
        rd_val[F_ASG_A +: N_LIN] = asg_a_r[LIN_LO +: N_LIN];
        rd_val[F_ASG_B +: N_LIN] = asg_b_r[LIN_LO +: N_LIN];
      end
      OFS_MODE: begin
        rd_val[N_RES-1:0]          = mode_act_r;
        rd_val[F_MODE_SLP +: N_RES] = mode_slp_r;
      end
      OFS_SW_EN:  rd_val[N_RES-1:0] = sw_en_r;
      OFS_STATUS: begin
        rd_val[2:0]        = state_r;
        rd_val[F_STAT_RUN] = running;
      end
      OFS_EDGES:  rd_val[5:0] = edg_r;
      OFS_RES_STAT: begin
        rd_val[N_RES-1:0]         = res_on_r;
        rd_val[F_RES_LP +: N_RES] = res_lp_r;
      end
      default: rd_val = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata_r <= '0;
    end else if (ce & rd_pend_r) begin
      hrdata_r <= rd_val;
    end
  end

endmodule
`default_nettype wire

// File: dv/swrmc_host_model.sv
// host model driving the sleep request pin and both direct mode pins
`timescale 1ns/1ns
`default_nettype none
module swrmc_host_model (
  input  wire logic clk,        // clock
  input  wire logic want_sleep, // 1 asks for sleep
  input  wire logic want_a,     // 1 asks active mode on pin a
  input  wire logic want_b,     // 1 asks active mode on pin b
  output var  logic slp_pin,    // sleep request pin
  output var  logic pin_a,      // direct pin a
  output var  logic pin_b       // direct pin b
);
  initial {slp_pin, pin_a, pin_b} = 3'b100;
  // pins move just after the edge, like a host gpio, never mid-cycle
  always @(posedge clk) begin
    slp_pin <= ~want_sleep;
    pin_a   <= want_a;
    pin_b   <= want_b;
  end
endmodule
`default_nettype wire

// File: dv/swrmc_properties.sv
// assertion checker for the sleep/wake control top ports
`timescale 1ns/1ns
`default_nettype none
module swrmc_properties
  import swrmc_pkg::*;
(
  input wire logic        clk,               // clock
  input wire logic        srst,              // reset
  input wire logic        ce,                // clock enable
  input wire logic        sleep_request_pin, // sleep pin
  input wire logic        irq_pending,       // pending irq
  input wire logic        off_req,           // off request
  input wire logic [11:0] res_on,            // enabled
  input wire logic [11:0] res_lowpower,      // in sleep mode
  input wire logic [2:0]  pwr_state          // state code
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ===========================================================
  // state flow
  a_sleep_gated: assert property (
    ce && pwr_state == ST_ACT && irq_pending && !off_req |=> pwr_state == ST_ACT)
    else $error("left active with irq pending");
  a_sleep_path: assert property (
    pwr_state == ST_LOAD && $past(pwr_state) == ST_ACT && !$past(off_req) |-> !$past(irq_pending))
    else $error("sleep sequence began with irq pending");
  // holds only under default pin polarity
  a_sleep_holds: assert property (
    ce && pwr_state == ST_SLP && !irq_pending && !off_req && !sleep_request_pin
    && !$past(sleep_request_pin) && !$past(sleep_request_pin, 2) |=> pwr_state == ST_SLP)
    else $error("sleep left without wake source");
  a_off_first: assert property (
    ce && off_req && (pwr_state == ST_ACT || pwr_state == ST_SLP) |=> pwr_state == ST_LOAD)
    else $error("off request not taken");
  a_load_wait: assert property (
    ce && pwr_state == ST_LOAD && !off_req |=> pwr_state == ST_WAIT)
    else $error("step load not followed by wait");
  // bound sized for the short bench tick
  a_wait_bound: assert property (
    pwr_state == ST_WAIT |-> ##[1:600] pwr_state != ST_WAIT)
    else $error("step wait never ends");
  a_seq_entry: assert property (
    pwr_state inside {ST_ACT, ST_SLP} && $changed(pwr_state) |-> $past(pwr_state) == ST_WAIT)
    else $error("mode state reached without sequence");
  a_off_dark: assert property (
    pwr_state == ST_OFF [*3] |-> res_on == 12'h000)
    else $error("resource on while off");
  cover property (pwr_state == ST_SLP);
  cover property (off_req && pwr_state == ST_ACT);
  cover property ($rose(res_lowpower[0]) && pwr_state == ST_ACT);
endmodule
bind swrmc_top swrmc_properties u_swrmc_properties (.clk, .srst, .ce, .sleep_request_pin,
  .irq_pending, .off_req, .res_on, .res_lowpower, .pwr_state);
`default_nettype wire

// File: dv/test_sleep_wake_resource_mode_control.sv
// self-checking bench for the sleep/wake resource mode control
`timescale 1ns/1ns
`default_nettype none
module test_sleep_wake_resource_mode_control;
  import swrmc_pkg::*;
  typedef struct packed {logic a; logic b; logic [11:0] lp;} swrmc_row_t;
  logic        clk = 1'b0, srst = 1'b1, hwrite = 1'b0, irq_pending = 1'b0;
  logic        on_req = 1'b0, off_req = 1'b0, w_slp = 1'b0, w_a = 1'b0, w_b = 1'b0;
  logic        hreadyout, hresp, sp, pa, pb, gap = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  pwr_state;
  logic [11:0] res_on, res_lowpower;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  int          err_total = 0, n_compared = 0;
  swrmc_row_t  rows [4] = '{{1'b0, 1'b1, 12'h001}, {1'b1, 1'b0, 12'h002},
                            {1'b0, 1'b0, 12'h023}, {1'b1, 1'b1, 12'h000}};
  always #20 clk = ~clk;
  swrmc_host_model u_swrmc_host_model (.clk, .want_sleep(w_slp), .want_a(w_a), .want_b(w_b),
    .slp_pin(sp), .pin_a(pa), .pin_b(pb));
  swrmc_top #(.STEP_TICK_CYC(2)) u_swrmc_top (.clk, .srst, .ce(1'b1), .hsel(1'b1), .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .sleep_request_pin(sp), .direct_mode_ctrl_a(pa), .direct_mode_ctrl_b(pb),
    .irq_pending, .on_req, .off_req, .res_on, .res_lowpower, .pwr_state);
  // sw2 must reach sleep mode while sw4 is still active
  always @(negedge clk) if (pwr_state > ST_SLP && res_lowpower[2] && !res_lowpower[4]) gap = 1'b1;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ready is read before the edge, so the edge's own update cannot race
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic r;
    @(posedge clk);
    htrans <= 2'b10;
    haddr  <= {24'h0000_00, a};
    hwrite <= w;
    do begin
      @(negedge clk);
      r = hreadyout;
      @(posedge clk);
    end while (r !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(negedge clk);
      r = hreadyout;
      q = hrdata;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, q, exp);
  endtask
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    while (pwr_state !== s && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk("pwr_state", 32'(pwr_state), 32'(s));
  endtask
  task automatic fin(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    cyc(1);
    chk("reset outputs", {3'h0, hresp, pwr_state, res_on, res_lowpower, hreadyout},
        32'h0000_0001);
    rdc("mode", OFS_MODE, 32'h0000_0fff);
    rdc("edges", OFS_EDGES, 32'h0000_0000);
    wr(8'h3c, 32'hffff_ffff);
    rdc("unmapped", 8'h3c, 32'h0000_0000);
    wr(OFS_ASG_SW, 32'h0002_0114);
    wr(OFS_ASG_LIN, 32'h0001_0100);
    rdc("assign sw", OFS_ASG_SW, 32'h0002_0114);
    wr(OFS_CTRL, 32'h0000_0001);
    fin("registers");
    @(posedge clk) {w_a, w_b, on_req} <= 3'b111;
    wait_st(ST_ACT);
    @(posedge clk) on_req <= 1'b0;
    cyc(3);
    chk("power up res_on", 32'(res_on), 32'h0000_0c24);
    fin("power up");
    foreach (rows[i]) begin
      @(posedge clk) {w_a, w_b} <= {rows[i].a, rows[i].b};
      cyc(6);
      chk("lowpower", 32'(res_lowpower), 32'(rows[i].lp));
      chk("res_on", 32'(res_on), 32'(12'hc24 & ~rows[i].lp));
    end
    fin("direct pins");
    @(posedge clk) {irq_pending, w_slp} <= 2'b11;
    cyc(40);
    chk("sleep blocked", 32'(pwr_state), 32'(ST_ACT));
    @(posedge clk) irq_pending <= 1'b0;
    wait_st(ST_SLP);
    cyc(2);
    chk("sleep order", 32'(gap), 32'h0000_0001);
    chk("sleep lowpower", 32'(res_lowpower), 32'h0000_0014);
    chk("sleep res_on", 32'(res_on), 32'h0000_0c20);
    @(posedge clk) {on_req, w_a} <= 2'b10;
    cyc(20);
    chk("direct in sleep", 32'(res_lowpower), 32'h0000_0015);
    chk("no wake", 32'(pwr_state), 32'(ST_SLP));
    @(posedge clk) {on_req, w_a, irq_pending} <= 3'b011;
    wait_st(ST_ACT);
    cyc(2);
    chk("wake lowpower", 32'(res_lowpower), 32'h0000_0000);
    @(posedge clk) w_slp <= 1'b0;
    cyc(5);
    @(posedge clk) irq_pending <= 1'b0;
    @(posedge clk) w_slp <= 1'b1;
    wait_st(ST_SLP);
    @(posedge clk) w_slp <= 1'b0;
    wait_st(ST_ACT);
    fin("sleep and wake");
    @(posedge clk) w_slp <= 1'b1;
    wait_st(ST_WAIT);
    // cut the sequence only after sw2 has gone to sleep mode
    wait (res_lowpower[2]);
    @(posedge clk) off_req <= 1'b1;
    wait_st(ST_OFF);
    cyc(4);
    chk("abort res_on", 32'(res_on), 32'h0000_0000);
    @(posedge clk) {off_req, on_req, w_slp} <= 3'b010;
    wait_st(ST_ACT);
    chk("restart lowpower", 32'(res_lowpower), 32'h0000_0000);
    @(posedge clk) {off_req, on_req} <= 2'b10;
    wait_st(ST_OFF);
    fin("off requests");
    test_done();
  end
endmodule
`default_nettype wire
